// ---- logic/scd_bist.sv ----
// scd_bist: diagnosis and self-test sequencer for the thermistor pin, diodes, chip temperature,
// pressure and temperature signal paths and calculation paths
// assumes converters answer each request with a one-cycle done pulse and result word
// Functional notes
// - open check pulls pin above and below
// - per-channel range check of thermistor pin
// - checks run only when enabled; temperature calc always runs
// - compare result top byte with limit bytes
// - diode voltage outside limits sets diode fault
// - diode check only for select/gain 0 or 1
// - overheat check sets error when enabled
// - pressure path test once after power-up
// - bridge opened, stimulus drives pressure converter
// - application gain, stimulus byte per channel
// - pressure result top byte against limits
// - pressure calc test at start and cyclic
// - pressure calc needs exact equality
// - coefficients computed even if disabled
// - temperature path test at start and cyclic
// - temperature stimulus matched to channel-one gain
// - temperature path top byte against limits
// - temperature calc exact equality check
// - pin checks sequenced with pull resistors
`default_nettype none
module scd_bist #(
    parameter int CYCLE_PERIOD = 1000000, // cycles between self-test rounds
    parameter int RESULT_W = 16 // converter result width
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    // analogue front end
    input wire logic i_diag_cmp_high, // pin above high diag threshold (pin domain)
    input wire logic i_diag_cmp_low, // pin below low diag threshold (pin domain)
    input wire logic i_overheat_flag, // junction above limit (pin domain)
    output logic o_pullup_en,
    output logic o_pulldown_en,
    output logic [3:0] o_diag_code,
    output logic o_bridge_open_ch1,
    output logic o_bridge_open_ch2,
    output logic [7:0] o_pstim_level,
    output logic o_temp_stimulus_mode,
    output logic [1:0] o_temp_stim_gain,
    output logic o_overheat_meas,
    // converters: request, result with done pulse
    output logic o_conv_req,
    output logic [1:0] o_conv_sel, // 0 temp, 1 pressure ch1, 2 pressure ch2
    input wire logic i_conv_done,
    input wire logic [RESULT_W-1:0] i_conv_result,
    input wire logic i_diode_ch1, // channel one served by a diode
    input wire logic i_diode_ch2,
    // calculation engine
    output logic o_calc_req,
    output logic [1:0] o_calc_sel, // 0 temp, 1 pressure ch1, 2 pressure ch2
    output logic o_calc_test_mode, // use stored inputs not live data
    output logic o_coef_update, // temperature coefficients refresh
    input wire logic i_calc_done,
    input wire logic i_calc_match, // result equals stored expected word
    // error flags to the serial output
    output logic [11:0] o_errors,
    output logic o_overheat_code,
    output logic o_busy
);
    // refuse widths the top-byte compare cannot serve
    initial begin
        if (RESULT_W < 8 || CYCLE_PERIOD < 16) $error("scd_bist: bad parameters");
    end

    // registers
    logic [15:0] temp_limit_word_ch1, temp_limit_word_ch2;
    logic [15:0] pressure_stimulus_levels, temp_path_test_limits;
    logic [15:0] pressure_path_limits_ch1, pressure_path_limits_ch2;
    logic [9:0] enables;
    logic [7:0] chan_cfg; // [1:0] src1, [3:2] gain1, [5:4] src2, [7:6] gain2
    logic [11:0] errors;
    scd_pkg::scd_state_t state;
    logic startup_done; // first round finished
    logic [31:0] cycle_cnt; // counts to next round
    logic [15:0] settle_cnt;
    logic waiting; // request issued, awaiting done
    logic chan; // channel index inside a stage
    logic [2:0] sync_hi, sync_lo, sync_ot; // pin synchronisers
    logic cmp_high, cmp_low, ot_level; // filtered levels

    // range compare: top byte against max[15:8] and min[7:0]
    function automatic logic outside(input logic [7:0] val, input logic [15:0] lim);
        outside = (val < lim[7:0]) || (val > lim[15:8]);
    endfunction : outside

    wire logic [7:0] res_top = i_conv_result[RESULT_W-1 -: 8];
    wire logic [1:0] src1 = chan_cfg[1:0];
    wire logic [1:0] gain1 = chan_cfg[3:2];
    wire logic [1:0] src2 = chan_cfg[5:4];
    wire logic [1:0] gain2 = chan_cfg[7:6];
    wire logic diode_ok1 = i_diode_ch1 && !src1[1] && !gain1[1];
    wire logic diode_ok2 = i_diode_ch2 && !src2[1] && !gain2[1];
    // limit, enable and diode select of the channel under test
    wire logic [15:0] tlim = chan ? temp_limit_word_ch2 : temp_limit_word_ch1;
    wire logic range_en = chan ? enables[scd_pkg::EN_RANGE2] : enables[scd_pkg::EN_RANGE1];
    wire logic diode_sel = chan ? diode_ok2 : diode_ok1;
    wire logic [15:0] plim = chan ? pressure_path_limits_ch2 : pressure_path_limits_ch1;
    wire logic ppath_en = chan ? enables[scd_pkg::EN_PPATH2] : enables[scd_pkg::EN_PPATH1];
    wire logic pcalc_en = chan ? enables[scd_pkg::EN_PCALC2] : enables[scd_pkg::EN_PCALC1];
    wire logic settled = (settle_cnt == 16'(scd_pkg::SETTLE_CYCLES));
    wire logic round_due = (cycle_cnt == 32'(CYCLE_PERIOD - 1));
    // enable-word write
    wire logic wr_en = i_reg_wr && (i_reg_addr == scd_pkg::ADDR_ENABLES);
    // compare outcomes watched by the result assertions
    wire logic range_bad1 = outside(res_top, temp_limit_word_ch1);
    wire logic tpath_bad = outside(res_top, temp_path_test_limits);

    // pin inputs: three flops, change taken when second and third agree
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_hi <= 3'h0;
            sync_lo <= 3'h0;
            sync_ot <= 3'h0;
            cmp_high <= 1'b0;
            cmp_low <= 1'b0;
            ot_level <= 1'b0;
        end else begin
            sync_hi <= {sync_hi[1:0], i_diag_cmp_high};
            sync_lo <= {sync_lo[1:0], i_diag_cmp_low};
            sync_ot <= {sync_ot[1:0], i_overheat_flag};
            if (sync_hi[1] == sync_hi[2]) cmp_high <= sync_hi[2];
            if (sync_lo[1] == sync_lo[2]) cmp_low <= sync_lo[2];
            if (sync_ot[1] == sync_ot[2]) ot_level <= sync_ot[2];
        end
    end

    // register writes
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            temp_limit_word_ch1 <= 16'h0000;
            temp_limit_word_ch2 <= 16'h0000;
            pressure_stimulus_levels <= 16'h0000;
            temp_path_test_limits <= 16'h0000;
            pressure_path_limits_ch1 <= 16'h0000;
            pressure_path_limits_ch2 <= 16'h0000;
            enables <= 10'h000;
            chan_cfg <= 8'h00;
        end else if (i_reg_wr) begin
            if (i_reg_addr == scd_pkg::ADDR_TEMP_LIM_CH1) temp_limit_word_ch1 <= i_reg_wdata;
            else if (i_reg_addr == scd_pkg::ADDR_TEMP_LIM_CH2) temp_limit_word_ch2 <= i_reg_wdata;
            else if (i_reg_addr == scd_pkg::ADDR_PSTIM_LEVELS) pressure_stimulus_levels <= i_reg_wdata;
            else if (i_reg_addr == scd_pkg::ADDR_TPATH_LIMITS) temp_path_test_limits <= i_reg_wdata;
            else if (i_reg_addr == scd_pkg::ADDR_PPATH_LIM_CH1) pressure_path_limits_ch1 <= i_reg_wdata;
            else if (i_reg_addr == scd_pkg::ADDR_PPATH_LIM_CH2) pressure_path_limits_ch2 <= i_reg_wdata;
            else if (wr_en) enables <= i_reg_wdata[9:0];
            else if (i_reg_addr == scd_pkg::ADDR_CHAN_CFG) chan_cfg <= i_reg_wdata[7:0];
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            if (i_reg_addr == scd_pkg::ADDR_TEMP_LIM_CH1) o_reg_rdata <= temp_limit_word_ch1;
            else if (i_reg_addr == scd_pkg::ADDR_TEMP_LIM_CH2) o_reg_rdata <= temp_limit_word_ch2;
            else if (i_reg_addr == scd_pkg::ADDR_PSTIM_LEVELS) o_reg_rdata <= pressure_stimulus_levels;
            else if (i_reg_addr == scd_pkg::ADDR_TPATH_LIMITS) o_reg_rdata <= temp_path_test_limits;
            else if (i_reg_addr == scd_pkg::ADDR_PPATH_LIM_CH1) o_reg_rdata <= pressure_path_limits_ch1;
            else if (i_reg_addr == scd_pkg::ADDR_PPATH_LIM_CH2) o_reg_rdata <= pressure_path_limits_ch2;
            else if (i_reg_addr == scd_pkg::ADDR_ENABLES) o_reg_rdata <= {6'h00, enables};
            else if (i_reg_addr == scd_pkg::ADDR_CHAN_CFG) o_reg_rdata <= {8'h00, chan_cfg};
            else if (i_reg_addr == scd_pkg::ADDR_ERRORS) o_reg_rdata <= {4'h0, errors};
            else if (i_reg_addr == scd_pkg::ADDR_STATUS) o_reg_rdata <= {11'h000, startup_done,
                                                                     state};
            else o_reg_rdata <= 16'h0000;
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end

    // sequencer: one stage after another, then wait for the next round
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= scd_pkg::ST_IDLE;
            errors <= '0;
            startup_done <= 1'b0;
            cycle_cnt <= 32'h0000_0000;
            settle_cnt <= 16'h0000;
            waiting <= 1'b0;
            chan <= 1'b0;
        end else begin
            // free-running round timer
            cycle_cnt <= round_due ? 32'h0000_0000 : cycle_cnt + 32'h0000_0001;
            case (state)
                scd_pkg::ST_IDLE: begin
                    // new round starts at channel one
                    settle_cnt <= 16'h0000;
                    chan <= 1'b0;
                    state <= scd_pkg::ST_OPEN_HI;
                end
                scd_pkg::ST_OPEN_HI: begin
                    // pull up and settle before sampling
                    if (!enables[scd_pkg::EN_OPEN]) begin
                        state <= scd_pkg::ST_RANGE;
                    end else if (settled) begin
                        settle_cnt <= 16'h0000;
                        errors[scd_pkg::ER_OPEN] <= !cmp_high;
                        state <= scd_pkg::ST_OPEN_LO;
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                scd_pkg::ST_OPEN_LO: begin
                    // then pull down; a high-phase failure is kept
                    if (!enables[scd_pkg::EN_OPEN]) begin
                        settle_cnt <= 16'h0000;
                        state <= scd_pkg::ST_RANGE;
                    end else if (settled) begin
                        settle_cnt <= 16'h0000;
                        errors[scd_pkg::ER_OPEN] <= errors[scd_pkg::ER_OPEN] || !cmp_low;
                        state <= scd_pkg::ST_RANGE;
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                scd_pkg::ST_RANGE: begin
                    // one conversion per enabled channel
                    if (!waiting && !range_en) begin
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_OVERHEAT;
                    end else if (!waiting) begin
                        waiting <= 1'b1;
                    end else if (i_conv_done) begin
                        waiting <= 1'b0;
                        errors[scd_pkg::ER_RANGE1 + chan] <= outside(res_top, tlim);
                        errors[scd_pkg::ER_DIODE1 + chan] <= diode_sel
                            && outside(res_top, tlim);
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_OVERHEAT;
                    end
                end
                scd_pkg::ST_OVERHEAT: begin
                    if (enables[scd_pkg::EN_OVERHEAT]) errors[scd_pkg::ER_OVERHEAT] <= ot_level;
                    state <= startup_done ? scd_pkg::ST_PCALC : scd_pkg::ST_PPATH;
                end
                scd_pkg::ST_PPATH: begin
                    // start-up only, bridge opened
                    if (!waiting && !ppath_en) begin
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_PCALC;
                    end else if (!waiting) begin
                        waiting <= 1'b1;
                    end else if (i_conv_done) begin
                        waiting <= 1'b0;
                        errors[scd_pkg::ER_PPATH1 + chan] <= outside(res_top, plim);
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_PCALC;
                    end
                end
                scd_pkg::ST_PCALC: begin
                    // engine runs on stored inputs
                    if (!waiting && !pcalc_en) begin
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_TPATH;
                    end else if (!waiting) begin
                        waiting <= 1'b1;
                    end else if (i_calc_done) begin
                        waiting <= 1'b0;
                        errors[scd_pkg::ER_PCALC1 + chan] <= !i_calc_match;
                        chan <= !chan;
                        if (chan) state <= scd_pkg::ST_TPATH;
                    end
                end
                scd_pkg::ST_TPATH: begin
                    // converter sees internal stimulus
                    if (!waiting && !enables[scd_pkg::EN_TPATH]) begin
                        state <= scd_pkg::ST_TCALC;
                    end else if (!waiting) begin
                        waiting <= 1'b1;
                    end else if (i_conv_done) begin
                        waiting <= 1'b0;
                        errors[scd_pkg::ER_TPATH] <= outside(res_top, temp_path_test_limits);
                        state <= scd_pkg::ST_TCALC;
                    end
                end
                scd_pkg::ST_TCALC: begin
                    // always runs; flag only when enabled
                    if (!waiting) begin
                        waiting <= 1'b1;
                    end else if (i_calc_done) begin
                        waiting <= 1'b0;
                        if (enables[scd_pkg::EN_TCALC]) begin
                            errors[scd_pkg::ER_TCALC] <= !i_calc_match;
                        end
                        startup_done <= 1'b1;
                        state <= scd_pkg::ST_WAIT;
                    end
                end
                scd_pkg::ST_WAIT: begin
                    // hold until the round timer expires
                    if (round_due) state <= scd_pkg::ST_IDLE;
                end
                default: state <= scd_pkg::ST_IDLE;
            endcase
        end
    end

    // analogue and engine controls decoded from the stage
    wire logic in_ppath = (state == scd_pkg::ST_PPATH);
    assign o_pullup_en = (state == scd_pkg::ST_OPEN_HI) && enables[scd_pkg::EN_OPEN];
    assign o_pulldown_en = (state == scd_pkg::ST_OPEN_LO) && enables[scd_pkg::EN_OPEN];
    assign o_diag_code = o_pullup_en ? scd_pkg::DIAG_CODE_HIGH
                       : o_pulldown_en ? scd_pkg::DIAG_CODE_LOW : scd_pkg::DIAG_CODE_NONE;
    assign o_bridge_open_ch1 = in_ppath && !chan && ppath_en;
    assign o_bridge_open_ch2 = in_ppath && chan && ppath_en;
    assign o_pstim_level = chan ? pressure_stimulus_levels[15:8]
                                : pressure_stimulus_levels[7:0];
    assign o_temp_stimulus_mode = (state == scd_pkg::ST_TPATH) && enables[scd_pkg::EN_TPATH];
    assign o_temp_stim_gain = gain1;
    assign o_overheat_meas = enables[scd_pkg::EN_OVERHEAT];
    // requests stand until their done pulse
    assign o_conv_req = waiting && (state == scd_pkg::ST_RANGE || in_ppath
                                    || state == scd_pkg::ST_TPATH);
    assign o_conv_sel = in_ppath ? (chan ? 2'h2 : 2'h1) : 2'h0;
    assign o_calc_req = waiting && (state == scd_pkg::ST_PCALC || state == scd_pkg::ST_TCALC);
    assign o_calc_sel = (state == scd_pkg::ST_PCALC) ? (chan ? 2'h2 : 2'h1) : 2'h0;
    assign o_calc_test_mode = o_calc_req;
    assign o_coef_update = (state == scd_pkg::ST_TCALC) && waiting;
    assign o_errors = errors;
    assign o_overheat_code = errors[scd_pkg::ER_OVERHEAT];
    assign o_busy = (state != scd_pkg::ST_WAIT);

    // open check drives pull-up then pull-down, never both
    a_pull_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !(o_pullup_en && o_pulldown_en)) else $error("pull resistors both on");
    // disabled open check leaves its flag unchanged
    a_open_gated: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !enables[scd_pkg::EN_OPEN] |=> $stable(errors[scd_pkg::ER_OPEN]))
        else $error("open check ran disabled");
    // range result follows comparison of top byte
    a_range_result: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state == scd_pkg::ST_RANGE && waiting && i_conv_done && !chan
        |=> errors[scd_pkg::ER_RANGE1] == $past(range_bad1)) else $error("range flag wrong");
    // temperature path flag follows its limit word
    a_tpath_result: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state == scd_pkg::ST_TPATH && waiting && i_conv_done
        |=> errors[scd_pkg::ER_TPATH] == $past(tpath_bad)) else $error("path flag wrong");
    // pressure path test only before start-up completes
    a_ppath_once: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        startup_done |-> state != scd_pkg::ST_PPATH) else $error("path test repeated");
    // calc mismatch sets the channel error
    a_pcalc_exact: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state == scd_pkg::ST_PCALC && waiting && i_calc_done && !i_calc_match
        |=> errors[scd_pkg::ER_PCALC1 + $past(chan)]) else $error("calc mismatch lost");
    // every round ends through a coefficient refresh
    a_coef_round: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(o_busy) |-> $past(o_coef_update)) else $error("coefficients skipped");
    // temperature stimulus only during its stage
    a_tstim_stage: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_temp_stimulus_mode |-> state == scd_pkg::ST_TPATH && o_temp_stim_gain == gain1)
        else $error("stimulus outside stage");
    // diode fault implies range fault of channel two
    a_diode_fault: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(errors[scd_pkg::ER_DIODE2]) |-> errors[scd_pkg::ER_RANGE2])
        else $error("diode fault without range");
endmodule : scd_bist
`default_nettype wire

// ---- logic/scd_pkg.sv ----
// scd_pkg: register map, field layout, timing and state types for the sensor diagnosis sequencer
// assumes a plain register port with one-cycle strobes and a 100 MHz system clock
`default_nettype none
package scd_pkg;
    // register offsets
    localparam logic [3:0] ADDR_TEMP_LIM_CH1 = 4'h0;
    localparam logic [3:0] ADDR_TEMP_LIM_CH2 = 4'h1;
    localparam logic [3:0] ADDR_PSTIM_LEVELS = 4'h2;
    localparam logic [3:0] ADDR_TPATH_LIMITS = 4'h3;
    localparam logic [3:0] ADDR_PPATH_LIM_CH1 = 4'h4;
    localparam logic [3:0] ADDR_PPATH_LIM_CH2 = 4'h5;
    localparam logic [3:0] ADDR_ENABLES = 4'h6;
    localparam logic [3:0] ADDR_CHAN_CFG = 4'h7;
    localparam logic [3:0] ADDR_ERRORS = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    // enable bit positions
    localparam int EN_OPEN = 0;
    localparam int EN_RANGE1 = 1;
    localparam int EN_RANGE2 = 2;
    localparam int EN_OVERHEAT = 3;
    localparam int EN_PPATH1 = 4;
    localparam int EN_PPATH2 = 5;
    localparam int EN_PCALC1 = 6;
    localparam int EN_PCALC2 = 7;
    localparam int EN_TPATH = 8;
    localparam int EN_TCALC = 9;
    // error bit positions
    localparam int ER_OPEN = 0;
    localparam int ER_RANGE1 = 1;
    localparam int ER_RANGE2 = 2;
    localparam int ER_DIODE1 = 3;
    localparam int ER_DIODE2 = 4;
    localparam int ER_OVERHEAT = 5;
    localparam int ER_PPATH1 = 6;
    localparam int ER_PPATH2 = 7;
    localparam int ER_PCALC1 = 8;
    localparam int ER_PCALC2 = 9;
    localparam int ER_TPATH = 10;
    localparam int ER_TCALC = 11;
    localparam int NUM_ERR = 12;
    // diagnostic comparator codes for the open check
    localparam logic [3:0] DIAG_CODE_HIGH = 4'hA;
    localparam logic [3:0] DIAG_CODE_LOW = 4'hB;
    localparam logic [3:0] DIAG_CODE_NONE = 4'h0;
    // suited temperature path limit words per gain
    localparam logic [15:0] TPATH_LIM_GAIN01 = 16'h6F61;
    localparam logic [15:0] TPATH_LIM_GAIN2 = 16'h3F31;
    localparam logic [15:0] TPATH_LIM_GAIN3 = 16'h8779;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_NS = 2000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_OPEN_HI, ST_OPEN_LO, ST_RANGE, ST_OVERHEAT, ST_PPATH,
        ST_PCALC, ST_TPATH, ST_TCALC, ST_WAIT
    } scd_state_t;
endpackage : scd_pkg
`default_nettype wire

// ---- testbench/scd_front_model.sv ----
// scd_front_model: stand-in for a converter or the calculation engine on the far side
// assumes a level request held until a one-cycle done pulse, as the sequencer drives it
`default_nettype none
module scd_front_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_lat, // answer delay in cycles
    input wire logic i_req, // level request from the sequencer
    input wire logic [15:0] i_answer, // value shown with done
    output logic o_done,
    output logic [15:0] o_data // scrambled outside the done cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt; // wait counter
    wire logic fire = i_req && !o_done && cnt >= i_lat; // answer due now
    // answer once per request after the set delay, data toggles when not valid
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {cnt, o_done, o_data} <= '0;
        end else begin
            o_done <= fire;
            cnt <= (i_req && !o_done && !fire) ? cnt + 8'h01 : 8'h00;
            o_data <= fire ? i_answer : ~o_data;
        end
    end
endmodule : scd_front_model
`default_nettype wire

// ---- testbench/test_sensor_channel_diagnosis_bist.sv ----
// test_sensor_channel_diagnosis_bist: self-checking bench for the diagnosis sequencer
// assumes scd_pkg, scd_bist and scd_front_model are compiled before it
`default_nettype none
module test_sensor_channel_diagnosis_bist;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, ovh = 1, pin_ok = 1;
    logic [3:0] addr = 0;
    logic [15:0] wdata = 0, stim = 0;
    logic [7:0] lat = 30; // slow answers first
    logic [2:0] match = 3'b010; // calc match per select: temp, p1, p2
    logic [15:0] vals [8]; // register image by offset
    logic [15:0] exp_q [$]; // expected read data
    int bad_count = 0, checked = 0;
    wire logic [15:0] rdata, cres, tres;
    wire logic [11:0] errs;
    wire logic [3:0] code;
    wire logic [7:0] plev;
    wire logic [1:0] csel, ksel, tgain;
    wire logic pu, pd, bo1, bo2, tsm, creq, kreq, cdone, kdone, busy, ohc, ohm, ktm;
    // comparators see the pin only while a pull is on and the pin is connected
    wire logic cmp_h = pu & pin_ok;
    wire logic cmp_l = pd & pin_ok;
    scd_bist #(.CYCLE_PERIOD(100)) i_scd_bist (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_diag_cmp_high(cmp_h), .i_diag_cmp_low(cmp_l),
        .i_overheat_flag(ovh), .o_pullup_en(pu), .o_pulldown_en(pd), .o_diag_code(code),
        .o_bridge_open_ch1(bo1), .o_bridge_open_ch2(bo2), .o_pstim_level(plev),
        .o_temp_stimulus_mode(tsm), .o_temp_stim_gain(tgain), .o_overheat_meas(ohm),
        .o_conv_req(creq), .o_conv_sel(csel), .i_conv_done(cdone), .i_conv_result(cres),
        .i_diode_ch1(1'b0), .i_diode_ch2(1'b1), .o_calc_req(kreq), .o_calc_sel(ksel),
        .o_calc_test_mode(ktm), .o_coef_update(), .i_calc_done(kdone), .i_calc_match(tres[0]),
        .o_errors(errs), .o_overheat_code(ohc), .o_busy(busy));
    // converter: temperature top byte 0x68, pressure top byte 0x50
    scd_front_model i_conv (.i_clk(clk), .i_reset_n(rst_n), .i_lat(lat), .i_req(creq),
        .i_answer({csel == 2'h0 ? 8'h68 : 8'h50, 8'hA5}), .o_done(cdone), .o_data(cres));
    scd_front_model i_calc (.i_clk(clk), .i_reset_n(rst_n), .i_lat(lat), .i_req(kreq),
        .i_answer({15'h0000, match[ksel]}), .o_done(kdone), .o_data(tres));
    task automatic check(input string what, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // bus cycles start just after an edge; strobes may run back to back
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
    endtask : wreg
    task automatic rreg(input logic [3:0] a, input logic [15:0] d);
        exp_q.push_back(d);
        wr <= 1'b0;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
    endtask : rreg
    task automatic idle;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : idle
    // bounded wait for a busy level, sampled mid-cycle
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; busy !== lvl && n < 20000; n++) @(negedge clk);
        if (n >= 20000) begin
            bad_count++;
            give_verdict();
        end
        @(posedge clk);
    endtask : wait_busy
    // read data stands one cycle after its strobe; side outputs watched mid-cycle
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) check("read data", rdata, exp_q.pop_front());
        if (pu) check("code", {12'h000, code}, {12'h000, scd_pkg::DIAG_CODE_HIGH});
        if (pd) check("code", {12'h000, code}, {12'h000, scd_pkg::DIAG_CODE_LOW});
        if (bo2) check("stim level", {8'h00, plev}, {8'h00, stim[15:8]});
        if (bo1) check("stim level", {8'h00, plev}, {8'h00, stim[7:0]});
        if (kreq) check("test mode", {15'h0000, ktm}, 16'h0001);
        if (tsm) check("stim gain", {14'h0000, tgain}, 16'h0000);
    end
    initial forever #5 clk = ~clk;
    initial begin
        stim = 16'($urandom(32'hDDD4));
        vals = '{16'h8010, 16'h6010, stim, scd_pkg::TPATH_LIM_GAIN01, 16'h6040, 16'h4030,
            16'h03FF, 16'h0000};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wreg(scd_pkg::ADDR_ENABLES, 16'h03FF);
        for (int a = 0; a < 8; a++) wreg(4'(a), vals[a]);
        wreg(4'hF, 16'hFFFF);
        for (int a = 0; a < 8; a++) rreg(4'(a), vals[a]);
        rreg(4'hF, 16'h0000);
        idle();
        $display("register test done");
        wait_busy(1'b0);
        rreg(scd_pkg::ADDR_ERRORS, 16'h0AB4);
        idle();
        check("overheat code", {15'h0000, ohc}, 16'h0001);
        check("overheat meas", {15'h0000, ohm}, 16'h0001);
        $display("start-up round done");
        ovh <= 1'b0;
        pin_ok <= 1'b0;
        match <= 3'b111;
        lat <= 8'h02;
        wreg(scd_pkg::ADDR_CHAN_CFG, 16'h0080);
        idle();
        wait_busy(1'b1);
        wait_busy(1'b0);
        rreg(scd_pkg::ADDR_ERRORS, 16'h0085);
        idle();
        $display("cyclic round done");
        pin_ok <= 1'b1;
        match <= 3'b000;
        wreg(scd_pkg::ADDR_ENABLES, 16'h0000);
        idle();
        wait_busy(1'b1);
        wait_busy(1'b0);
        rreg(scd_pkg::ADDR_ERRORS, 16'h0085);
        check("overheat meas", {15'h0000, ohm}, 16'h0000);
        idle();
        rst_n <= 1'b0;
        @(posedge clk);
        check("errors after reset", {4'h0, errs}, 16'h0000);
        $display("disable and reset test done");
        give_verdict();
    end
endmodule : test_sensor_channel_diagnosis_bist
`default_nettype wire
